// ==== bench/pps_link_assertions.sv ====
`timescale 1ns/100ps
module pps_link_assertions
(
   input wire logic       sys_clk,
   input wire logic       rst_b,
   input wire logic [7:0] paLine,
   input wire logic [7:0] pbDevOe,
   input wire logic [7:0] pcDevOe,
   input wire logic [7:0] pcLine
);
   // ----------------------------------------------------------
   // group modes as seen from the device's drive enables
   // ----------------------------------------------------------
   // enables are hidden from the wire, so only request-implies-flag
   // can be watched here; the bench checks the enable side
   wire aIn;
   wire aOut;
   wire bStr;
   wire bIn;
   wire bOut;
   assign aIn  = pcDevOe[5] & ~pcDevOe[4];
   assign aOut = pcDevOe[7] & ~pcDevOe[6];
   assign bStr = pcDevOe[1] & ~pcDevOe[2];
   assign bIn  = bStr & (pbDevOe == 8'h00);
   assign bOut = bStr & (pbDevOe == 8'hFF);

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   sequence sEdgeA;
      $fell(pcLine[4]) ##0 !pcLine[5];
   endsequence
   sequence sAckA;
      $fell(pcLine[6]) ##0 !pcLine[7];
   endsequence
   sequence sEdgeB;
      $fell(pcLine[2]) ##0 !pcLine[1];
   endsequence

   AST_A_IN_IRQ:
   assert property (aIn && pcLine[3] |-> pcLine[5])
      else $error("group A input request without full flag");
   AST_B_IN_IRQ:
   assert property (bIn && pcLine[0] |-> pcLine[1])
      else $error("group B input request without full flag");
   AST_A_OUT_IRQ:
   assert property (aOut && pcLine[3] |-> pcLine[7])
      else $error("group A output request while buffer full");
   AST_B_OUT_IRQ:
   assert property (bOut && pcLine[0] |-> pcLine[1])
      else $error("group B output request while buffer full");
   AST_A_IN_STB:
   assert property (aIn ##0 sEdgeA |-> ##[1:2] pcLine[5])
      else $error("group A strobe did not set full flag");
   AST_B_IN_STB:
   assert property (bIn ##0 sEdgeB |-> ##[1:2] pcLine[1])
      else $error("group B strobe did not set full flag");
   AST_A_OUT_ACK:
   assert property (aOut ##0 sAckA |-> ##[1:2] pcLine[7])
      else $error("group A acknowledge did not empty buffer");
   AST_B_OUT_ACK:
   assert property (bOut ##0 sEdgeB |-> ##[1:2] pcLine[1])
      else $error("group B acknowledge did not empty buffer");
   AST_A_OUT_HOLD:
   assert property (aOut && $past(aOut) && !pcLine[7] && !$past(pcLine[7])
                    |-> $stable(paLine))
      else $error("port A data moved while buffer full");
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
   logic            sys_clk;
   logic            rst_b;
   logic [7:0]      paddr;
   logic            psel;
   logic            penable;
   logic            pwrite;
   logic [31:0]     pwdata;
   logic [31:0]     prdata;
   logic            pready;
   logic            pslverr;
   logic [1:0]      sendMode;
   logic [1:0]      txValid;
   logic [1:0][7:0] txData;
   logic [1:0]      txReady;
   logic [1:0][7:0] rxData;
   logic [1:0]      rxValid;
   logic            lastErr;
   logic [31:0]     rdVal;
   int              bad_count;
   int              total_checks;

   pps_link_if link ();
   pps_port_dev i_pps_port_dev (.sys_clk(sys_clk), .rst_b(rst_b),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link));
   pps_port_peer i_pps_port_peer (.sys_clk(sys_clk), .rst_b(rst_b),
      .link(link), .sendMode(sendMode), .txValid(txValid),
      .txData(txData), .txReady(txReady), .rxData(rxData),
      .rxValid(rxValid));
   pps_link_assertions i_pps_link_assertions (.sys_clk(sys_clk),
      .rst_b(rst_b), .paLine(link.paLine), .pbDevOe(link.pbDevOe),
      .pcDevOe(link.pcDevOe), .pcLine(link.pcLine));

   always #50 sys_clk = ~sys_clk;

   // ----------------------------------------------------------
   // expected status words and shared checks
   // ----------------------------------------------------------
   function automatic logic [7:0] expA(input logic o, f, en);
      return o ? {f, en, 2'b00, en & f, 3'b000}
               : {2'b00, f, en, en & f, 3'b000};
   endfunction
   function automatic logic [7:0] expB(input logic f, en);
      return {5'b00000, en, f, en & f};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      r       = prdata;
      lastErr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      apb(1'b1, a, {24'h000000, d}, r);
   endtask

   // one byte across a group; m and e judge the status after the handshake: input buffer full, or output buffer emptied by the acknowledge
   task automatic xfer(input int g, input logic o, input logic [7:0] m,
                       input logic [7:0] e);
      logic [7:0]  d;
      logic [31:0] r;
      int          i;
      d = 8'($urandom);
      r = 32'h00000000;
      if (o)
      begin
         wr(8'(g * 4), d);
         #1;
         chk(32'(link.pcLine[g ? 1 : 7]), 32'h0);
         for (i = 0; i < 20 && rxValid[g] !== 1'b1; i++)
         begin
            @(posedge sys_clk);
            #1;
         end
         chk(32'(rxValid[g]), 32'h1);
         chk(32'(rxData[g]), 32'(d));
         apb(1'b0, 8'h08, 32'h0, r);
      end
      else
      begin
         @(posedge sys_clk);
         txData[g]  <= d;
         txValid[g] <= 1'b1;
         #1;
         for (i = 0; i < 20 && txReady[g] !== 1'b1; i++)
         begin
            @(posedge sys_clk);
            #1;
         end
         chk(32'(txReady[g]), 32'h1);
         @(posedge sys_clk);
         txValid[g] <= 1'b0;
         // the host side must see the full flag before reading data
         for (i = 0; i < 20 && r[g ? 1 : 5] !== 1'b1; i++)
            apb(1'b0, 8'h08, 32'h0, r);
      end
      chk(32'(r[7:0] & m), 32'(e));
      if (!o)
      begin
         apb(1'b0, 8'(g * 4), 32'h0, r);
         chk(r, 32'(d));
      end
   endtask

   // ----------------------------------------------------------
   // group tests
   // ----------------------------------------------------------
   task automatic runA(input logic o);
      int en;
      @(posedge sys_clk);
      wr(8'h0C, o ? 8'hA0 : 8'hB0);
      // switch the peer only once the flag line shows the new mode
      sendMode[0] <= !o;
      apb(1'b0, 8'h08, 32'h0, rdVal);
      chk(rdVal & 32'hF8, 32'(expA(o, o, 1'b0)));
      for (en = 1; en >= 0; en--)
      begin
         wr(8'h0C, {4'h0, o ? 3'h6 : 3'h4, 1'(en)});
         apb(1'b0, 8'h08, 32'h0, rdVal);
         chk(rdVal & 32'hF8, 32'(expA(o, o, 1'(en))));
         xfer(0, o, 8'hF8, expA(o, 1'b1, 1'(en)));
         apb(1'b0, 8'h08, 32'h0, rdVal);
         chk(rdVal & 32'hF8, 32'(expA(o, o, 1'(en))));
      end
      wr(8'h0C, o ? 8'h0B : 8'h0F);
      @(posedge sys_clk);
      #1;
      chk(32'(link.pcLine[o ? 5 : 7]), 32'h1);
      // the line idles high, so a low level proves the drive
      wr(8'h0C, o ? 8'h0A : 8'h0E);
      @(posedge sys_clk);
      #1;
      chk(32'(link.pcLine[o ? 5 : 7]), 32'h0);
      $display("group A %s test done", o ? "output" : "input");
   endtask

   task automatic runB(input logic o, input logic [7:0] cfg);
      int en;
      @(posedge sys_clk);
      wr(8'h0C, cfg);
      sendMode[1] <= !o;
      for (en = 1; en >= 0; en--)
      begin
         wr(8'h0C, {4'h0, 3'h2, 1'(en)});
         xfer(1, o, 8'h07, expB(1'b1, 1'(en)));
         apb(1'b0, 8'h08, 32'h0, rdVal);
         chk(rdVal & 32'h07, 32'(expB(o, 1'(en))));
      end
      $display("group B %s test done with %h", o ? "output" : "input", cfg);
   endtask

   initial
   begin
      #(5000 * 100);
      bad_count++;
      $display("watchdog expired");
      conclude();
   end

   initial
   begin
      sys_clk      = 1'b0;
      rst_b        = 1'b0;
      paddr        = 8'h00;
      psel         = 1'b0;
      penable      = 1'b0;
      pwrite       = 1'b0;
      pwdata       = 32'h00000000;
      // an idle sender ignores the flag, so an unused group never locks
      sendMode     = 2'h3;
      txValid      = 2'h0;
      txData       = 16'h0000;
      lastErr      = 1'b0;
      bad_count    = 0;
      total_checks = 0;
      void'($urandom(37766));
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      // unmapped address and the write-only configuration word
      apb(1'b0, 8'h10, 32'h0, rdVal);
      chk(rdVal, 32'h0);
      chk(32'(lastErr), 32'h1);
      apb(1'b0, 8'h0C, 32'h0, rdVal);
      chk(rdVal, 32'h0);
      chk(32'(lastErr), 32'h0);
      $display("register map test done");
      runA(1'b0);
      runA(1'b1);
      runB(1'b0, 8'h86);
      runB(1'b1, 8'h84);
      runB(1'b1, (8'($urandom) & 8'h19) | 8'h84);
      conclude();
   end
endmodule

// ==== core/pps_link_if.sv ====
`timescale 1ns/100ps
interface pps_link_if;
   logic [7:0] paDev;
   logic [7:0] paDevOe;
   logic [7:0] paPer;
   logic [7:0] paPerOe;
   logic [7:0] pbDev;
   logic [7:0] pbDevOe;
   logic [7:0] pbPer;
   logic [7:0] pbPerOe;
   logic [7:0] pcDev;
   logic [7:0] pcDevOe;
   logic [7:0] pcPer;
   logic [7:0] pcPerOe;
   wire  [7:0] paLine;
   wire  [7:0] pbLine;
   wire  [7:0] pcLine;

   // undriven lines resolve to one, as with a pull-up
   assign paLine = (paDevOe & paDev) | (paPerOe & paPer)
                 | ~(paDevOe | paPerOe);
   assign pbLine = (pbDevOe & pbDev) | (pbPerOe & pbPer)
                 | ~(pbDevOe | pbPerOe);
   assign pcLine = (pcDevOe & pcDev) | (pcPerOe & pcPer)
                 | ~(pcDevOe | pcPerOe);

   modport dev
   (
      output paDev, paDevOe, pbDev, pbDevOe, pcDev, pcDevOe,
      input  paLine, pbLine, pcLine
   );
   modport peer
   (
      output paPer, paPerOe, pbPer, pbPerOe, pcPer, pcPerOe,
      input  paLine, pbLine, pcLine
   );
endinterface

// ==== core/pps_pkg.sv ====
// Functional notes
// (RL1) two groups: 8-bit data plus 4-bit handshake
// (RL2) port A strobed input frees lines 7-6
// (RL3) port B strobed leaves no spare lines
// (RL4) input-full at status bit 5 and 1
// (RL5) group A input enable at bit 4, set/reset only
// (RL6) group B enable at bit 2, set/reset only
// (RL7) A input request equals enable and full
// (RL8) B input request equals enable and full
// (RL9) host drives spare outputs via set/reset only; the code also lets a port C write load the latch
// (RL10) strobe levels never shown in status word
// (RL11) port A strobed output frees lines 5-4
// (RL12) port B output: bit7=1, bit2=1, bit1=0
// (RL13) host write drives output-full flag low
// (RL14) group A output enable at bit 6
// (RL15) A output request equals enable and full_n
// (RL16) B output request equals enable and full_n
// (RL17) acknowledge levels never shown in status word
// (RL18) status layout follows each group's direction
// (RL19) 0xB0 selects A input, 0x86 B input
// (RL20) host polls full bit before reading data
// (RL21) bit 7 set means mode definition
// (RL22) strobe latches and sets full; read clears
// (RL23) write fills; acknowledge empties, raises request
package pps_pkg;
   // ----------------------------------------------------------
   // register indices, byte address is four times the index
   // ----------------------------------------------------------
   localparam logic [1:0] PPS_IDX_PORT_A   = 2'h0;
   localparam logic [1:0] PPS_IDX_PORT_B   = 2'h1;
   localparam logic [1:0] PPS_IDX_PORT_C   = 2'h2;
   localparam logic [1:0] PPS_IDX_CONFIG   = 2'h3;
   // ----------------------------------------------------------
   // configuration word fields
   // ----------------------------------------------------------
   localparam int         PPS_CFG_MODE_FLAG = 7;
   localparam int         PPS_CFG_A_MODE_HI = 6;
   localparam int         PPS_CFG_A_MODE_LO = 5;
   localparam int         PPS_CFG_A_IN      = 4;
   localparam int         PPS_CFG_CU_IN     = 3;
   localparam int         PPS_CFG_B_MODE    = 2;
   localparam int         PPS_CFG_B_IN      = 1;
   localparam int         PPS_CFG_CL_IN     = 0;
   localparam int         PPS_BSR_SEL_HI    = 3;
   localparam int         PPS_BSR_SEL_LO    = 1;
   localparam int         PPS_BSR_VAL       = 0;
   localparam logic [1:0] PPS_A_STROBED     = 2'h1;
   localparam logic [7:0] PPS_CFG_RESET     = 8'h9B;
   // ----------------------------------------------------------
   // port C line positions in strobed mode
   // ----------------------------------------------------------
   localparam logic [2:0] PPS_PC_INTR_B = 3'h0;
   localparam logic [2:0] PPS_PC_FLAG_B = 3'h1;
   localparam logic [2:0] PPS_PC_HS_B   = 3'h2;
   localparam logic [2:0] PPS_PC_INTR_A = 3'h3;
   localparam logic [2:0] PPS_PC_STB_A  = 3'h4;
   localparam logic [2:0] PPS_PC_IBF_A  = 3'h5;
   localparam logic [2:0] PPS_PC_ACK_A  = 3'h6;
   localparam logic [2:0] PPS_PC_OBF_A  = 3'h7;
   // ----------------------------------------------------------
   // timing of the peripheral's strobe and acknowledge
   // ----------------------------------------------------------
   localparam int PPS_CLK_NS    = 100;
   localparam int PPS_PULSE_NS  = 200;
   localparam int PPS_PULSE_CYC =
      (PPS_PULSE_NS + PPS_CLK_NS - 1) / PPS_CLK_NS;
   localparam logic [3:0] PPS_PULSE_LAST = 4'(PPS_PULSE_CYC - 1);
endpackage

// ==== core/pps_port_dev.sv ====
`timescale 1ns/100ps
module pps_port_dev
   import pps_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   pps_link_if.dev          link
);
   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   logic [7:0]  cfg_r;
   logic [7:0]  outA_r;
   logic [7:0]  outB_r;
   logic [7:0]  inA_r;
   logic [7:0]  inB_r;
   logic [7:0]  pcLat_r;
   logic        group_a_input_full_r;
   logic        group_b_input_full_r;
   logic        obfAN_r;
   logic        obfBN_r;
   logic        group_a_irq_enable_r;
   logic        group_b_irq_enable_r;
   logic        stbAPrev_r;
   logic        stbBPrev_r;
   logic        evtA_r;
   logic        evtB_r;
   logic [31:0] prdata_r;

   function automatic logic [7:0] setBit(input logic [7:0] v,
                                         input logic [2:0] sel,
                                         input logic       val);
      logic [7:0] r;
      r      = v;
      r[sel] = val;
      return r;
   endfunction

   // ----------------------------------------------------------
   // configuration decode
   // ----------------------------------------------------------
   wire aM1 = (cfg_r[PPS_CFG_A_MODE_HI:PPS_CFG_A_MODE_LO]
               == PPS_A_STROBED); // (RL19)
   wire aIn = cfg_r[PPS_CFG_A_IN];
   wire bM1 = cfg_r[PPS_CFG_B_MODE]; // (RL12)
   wire bIn = cfg_r[PPS_CFG_B_IN];
   wire cuOut = ~cfg_r[PPS_CFG_CU_IN];
   wire clOut = ~cfg_r[PPS_CFG_CL_IN];
   wire aM1In = aM1 & aIn;
   wire aM1Out = aM1 & ~aIn;
   wire [7:0] pc = link.pcLine;

   // ----------------------------------------------------------
   // bus decode; zero wait states
   // ----------------------------------------------------------
   wire       setup = psel & ~penable;
   wire       acc = psel & penable;
   wire       mapped = (paddr[7:4] == 4'h0) & (paddr[1:0] == 2'h0);
   wire [1:0] idx = paddr[3:2];
   wire       wrOk = acc & pwrite & mapped;
   wire       rdOk = acc & ~pwrite & mapped;
   wire       wrA = wrOk & (idx == PPS_IDX_PORT_A);
   wire       wrB = wrOk & (idx == PPS_IDX_PORT_B);
   wire       wrC = wrOk & (idx == PPS_IDX_PORT_C);
   wire       wrCfg = wrOk & (idx == PPS_IDX_CONFIG);
   wire       rdA = rdOk & (idx == PPS_IDX_PORT_A);
   wire       rdB = rdOk & (idx == PPS_IDX_PORT_B);
   wire       modeSet = wrCfg & pwdata[PPS_CFG_MODE_FLAG]; // (RL21)
   wire       bsr = wrCfg & ~pwdata[PPS_CFG_MODE_FLAG];
   wire [2:0] bsrSel = pwdata[PPS_BSR_SEL_HI:PPS_BSR_SEL_LO];
   wire       bsrVal = pwdata[PPS_BSR_VAL];

   // the enable lives where the strobe or acknowledge pin sits
   wire [2:0] inteAPos = aIn ? PPS_PC_STB_A : PPS_PC_ACK_A;
   wire bsrInteA = bsr & aM1 & (bsrSel == inteAPos); // (RL5) (RL14)
   wire bsrInteB = bsr & bM1 & (bsrSel == PPS_PC_HS_B); // (RL6)
   // set/reset of a spare line; direct writes also reach the latch
   wire bsrLine = bsr & ~bsrInteA & ~bsrInteB; // (RL9)

   // ----------------------------------------------------------
   // handshake events from the peripheral
   // ----------------------------------------------------------
   wire stbAFall = aM1In & stbAPrev_r & ~pc[PPS_PC_STB_A];
   wire stbBFall = bM1 & bIn & stbBPrev_r & ~pc[PPS_PC_HS_B];
   wire group_a_ack_n = aM1Out & ~pc[PPS_PC_ACK_A];
   wire group_b_ack_n = bM1 & ~bIn & ~pc[PPS_PC_HS_B];

   wire flagB = bIn ? group_b_input_full_r : obfBN_r;
   wire group_a_irq_request = group_a_irq_enable_r & (aIn ? group_a_input_full_r : obfAN_r); // (RL7) (RL15)
   wire group_b_irq_request = group_b_irq_enable_r & (bIn ? group_b_input_full_r : obfBN_r); // (RL8) (RL16)

   // ----------------------------------------------------------
   // port C direction and drive
   // ----------------------------------------------------------
   wire [7:0] pcOe;
   assign pcOe[7] = aM1Out | cuOut;
   assign pcOe[6] = ~aM1Out & cuOut; // (RL2)
   assign pcOe[5] = aM1In | cuOut;
   assign pcOe[4] = ~aM1In & cuOut; // (RL11)
   assign pcOe[3] = aM1 | clOut;
   assign pcOe[2] = ~bM1 & clOut; // (RL3)
   assign pcOe[1] = bM1 | clOut;
   assign pcOe[0] = bM1 | clOut;

   assign link.pcDevOe = pcOe; // (RL1)
   assign link.pcDev = {aM1Out ? obfAN_r : pcLat_r[7], pcLat_r[6],
                        aM1In ? group_a_input_full_r : pcLat_r[5], pcLat_r[4],
                        aM1 ? group_a_irq_request : pcLat_r[3], pcLat_r[2],
                        bM1 ? flagB : pcLat_r[1],
                        bM1 ? group_b_irq_request : pcLat_r[0]};
   assign link.paDev = outA_r;
   assign link.paDevOe = {8{~aIn}};
   assign link.pbDev = outB_r;
   assign link.pbDevOe = {8{~bIn}};

   // ----------------------------------------------------------
   // read side: status word replaces handshake pin levels
   // ----------------------------------------------------------
   wire [7:0] pcRead = (pcOe & pcLat_r) | (~pcOe & pc);
   wire [3:0] stUp = aM1In ? {pcRead[7:6], group_a_input_full_r, group_a_irq_enable_r} // (RL4)
                   : aM1Out ? {obfAN_r, group_a_irq_enable_r, pcRead[5:4]} // (RL18)
                   : pcRead[7:4]; // (RL10) (RL17)
   wire [2:0] stLo = bM1 ? {group_b_irq_enable_r, flagB, group_b_irq_request}
                   : pcRead[2:0];
   wire [7:0] status = {stUp, aM1 ? group_a_irq_request : pcRead[3], stLo};
   wire [7:0] rdA_v = aIn ? (aM1 ? inA_r : link.paLine) : outA_r;
   wire [7:0] rdB_v = bIn ? (bM1 ? inB_r : link.pbLine) : outB_r;
   wire [7:0] rdMux = (idx == PPS_IDX_PORT_A) ? rdA_v
                    : (idx == PPS_IDX_PORT_B) ? rdB_v
                    : (idx == PPS_IDX_PORT_C) ? status : 8'h00;

   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;

   // ----------------------------------------------------------
   // registers
   // ----------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg_r      <= PPS_CFG_RESET;
         outA_r     <= 8'h00;
         outB_r     <= 8'h00;
         pcLat_r    <= 8'h00;
         group_a_irq_enable_r    <= 1'b0;
         group_b_irq_enable_r    <= 1'b0;
         prdata_r   <= 32'h0000_0000;
      end
      else
      begin
         if (setup & ~pwrite)
            prdata_r <= mapped ? {24'h00_0000, rdMux} : 32'h0000_0000;
         if (modeSet)
         begin
            cfg_r   <= pwdata[7:0];
            pcLat_r <= 8'h00;
            group_a_irq_enable_r <= 1'b0;
            group_b_irq_enable_r <= 1'b0;
         end
         if (bsrInteA)
            group_a_irq_enable_r <= bsrVal;
         if (bsrInteB)
            group_b_irq_enable_r <= bsrVal;
         if (bsrLine)
            pcLat_r <= setBit(pcLat_r, bsrSel, bsrVal);
         if (wrC)
            pcLat_r <= pwdata[7:0];
         if (wrA)
            outA_r <= pwdata[7:0];
         if (wrB)
            outB_r <= pwdata[7:0];
      end
   end

   // a strobe in the setup cycle is not in prdata, so keep its flag
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         inA_r      <= 8'h00;
         inB_r      <= 8'h00;
         group_a_input_full_r     <= 1'b0;
         group_b_input_full_r     <= 1'b0;
         stbAPrev_r <= 1'b1;
         stbBPrev_r <= 1'b1;
         evtA_r     <= 1'b0;
         evtB_r     <= 1'b0;
      end
      else
      begin
         stbAPrev_r <= pc[PPS_PC_STB_A];
         stbBPrev_r <= pc[PPS_PC_HS_B];
         evtA_r     <= stbAFall;
         evtB_r     <= stbBFall;
         if (stbAFall)
            inA_r <= link.paLine; // (RL22)
         if (stbBFall)
            inB_r <= link.pbLine;
         if (modeSet)
            group_a_input_full_r <= 1'b0;
         else if (stbAFall)
            group_a_input_full_r <= 1'b1; // (RL22)
         else if (rdA & ~evtA_r)
            group_a_input_full_r <= 1'b0;
         if (modeSet)
            group_b_input_full_r <= 1'b0;
         else if (stbBFall)
            group_b_input_full_r <= 1'b1;
         else if (rdB & ~evtB_r)
            group_b_input_full_r <= 1'b0;
      end
   end

   // new data outranks a late acknowledge of the old byte
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         obfAN_r <= 1'b1;
         obfBN_r <= 1'b1;
      end
      else
      begin
         if (modeSet)
            obfAN_r <= 1'b1;
         else if (wrA & aM1Out)
            obfAN_r <= 1'b0; // (RL13)
         else if (group_a_ack_n)
            obfAN_r <= 1'b1; // (RL23)
         if (modeSet)
            obfBN_r <= 1'b1;
         else if (wrB & bM1 & ~bIn)
            obfBN_r <= 1'b0; // (RL13)
         else if (group_b_ack_n)
            obfBN_r <= 1'b1;
      end
   end
endmodule

// ==== core/pps_port_peer.sv ====
`timescale 1ns/100ps
module pps_port_peer
   import pps_pkg::*;
(
   input  wire logic            sys_clk,
   input  wire logic            rst_b,
   pps_link_if.peer             link,
   input  wire logic [1:0]      sendMode,
   input  wire logic [1:0]      txValid,
   input  wire logic [1:0][7:0] txData,
   output logic      [1:0]      txReady,
   output logic      [1:0][7:0] rxData,
   output logic      [1:0]      rxValid
);
   typedef enum logic [4:0]
   {
      PPS_IDLE  = 5'b00001,
      PPS_SETUP = 5'b00010,
      PPS_STRB  = 5'b00100,
      PPS_ACK   = 5'b01000,
      PPS_WAIT  = 5'b10000
   } pps_peer_e;

   // ----------------------------------------------------------
   // flag line seen per group: input-full or output-full_n
   // ----------------------------------------------------------
   logic [1:0] flagLine;
   logic [1:0] strobeN;
   logic [1:0] ackN;
   logic [1:0] driveData;
   logic [1:0][7:0] dataOut;

   assign flagLine[0] = sendMode[0] ? link.pcLine[PPS_PC_IBF_A]
                                    : link.pcLine[PPS_PC_OBF_A];
   assign flagLine[1] = link.pcLine[PPS_PC_FLAG_B];

   assign link.paPer   = dataOut[0];
   assign link.paPerOe = {8{driveData[0]}};
   assign link.pbPer   = dataOut[1];
   assign link.pbPerOe = {8{driveData[1]}};
   assign link.pcPer   = {1'b1, ackN[0], 1'b1, strobeN[0], 1'b1,
                          strobeN[1] & ackN[1], 2'h3};
   assign link.pcPerOe = {1'b0, ~sendMode[0], 1'b0, sendMode[0],
                          1'b0, 1'b1, 2'h0};

   // ----------------------------------------------------------
   // one handshake engine per group
   // ----------------------------------------------------------
   for (genvar g = 0; g < 2; g++)
   begin : grp
      pps_peer_e  state_r;
      pps_peer_e  state_nxt;
      logic [3:0] cnt_r;
      logic [7:0] data_r;
      logic       rxv_r;

      assign txReady[g]   = (state_r == PPS_IDLE) & sendMode[g]
                          & ~flagLine[g]; // (RL20)
      assign strobeN[g]   = ~(state_r == PPS_STRB);
      assign ackN[g]      = ~(state_r == PPS_ACK);
      assign driveData[g] = sendMode[g] &
                            ((state_r == PPS_SETUP) |
                             (state_r == PPS_STRB));
      assign dataOut[g]   = data_r;
      assign rxData[g]    = data_r;
      assign rxValid[g]   = rxv_r;

      always_comb
      begin
         state_nxt = state_r;
         case (state_r)
            PPS_IDLE:
               if (txValid[g] & txReady[g])
                  state_nxt = PPS_SETUP;
               else if (~sendMode[g] & ~flagLine[g])
                  state_nxt = PPS_ACK; // (RL23)
            PPS_SETUP: state_nxt = PPS_STRB;
            PPS_STRB:
               if (cnt_r == PPS_PULSE_LAST)
                  state_nxt = PPS_WAIT; // (RL22)
            PPS_ACK:
               if (cnt_r == PPS_PULSE_LAST)
                  state_nxt = PPS_WAIT;
            PPS_WAIT:
               if (flagLine[g])
                  state_nxt = PPS_IDLE;
            default: state_nxt = PPS_IDLE;
         endcase
      end

      always_ff @(posedge sys_clk or negedge rst_b)
      begin
         if (!rst_b)
         begin
            state_r <= PPS_IDLE;
            cnt_r   <= 4'h0;
            data_r  <= 8'h00;
            rxv_r   <= 1'b0;
         end
         else
         begin
            state_r <= state_nxt;
            cnt_r   <= (state_nxt == state_r) ? cnt_r + 4'h1 : 4'h0;
            rxv_r   <= (state_r == PPS_WAIT) & flagLine[g]
                     & ~sendMode[g];
            if (state_r == PPS_IDLE && txValid[g] && txReady[g])
               data_r <= txData[g];
            else if (state_r == PPS_ACK)
               data_r <= (g == 0) ? link.paLine : link.pbLine;
         end
      end
   end
endmodule
